/* core/lsib_tclk_watch.sv */
// Transmit clock loss watchdog for one channel.
// Assumes tx_clock_input is asynchronous to clk, the master clock.
module lsib_tclk_watch #(
   parameter int LIMIT = lsib_pkg::TCLK_LOSS_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic tx_clock_input,
   output logic loss_q
);

   logic [2:0] sync_q;
   logic [7:0] idle_q;
   logic [7:0] idle_d;
   logic loss_d;
   logic toggle;

   // ------------------------------------------------------------
   // Idle counter
   // ------------------------------------------------------------
   always_comb
   begin
      toggle = sync_q[1] ^ sync_q[2];
      if (toggle)
      begin
         idle_d = 8'h00;
      end
      else if (idle_q > LIMIT[7:0])
      begin
         idle_d = idle_q;
      end
      else
      begin
         idle_d = idle_q + 8'h01;
      end
      loss_d = idle_d > LIMIT[7:0];
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync_q <= 3'h0;
         idle_q <= 8'h00;
         loss_q <= 1'b0;
      end
      else
      begin
         sync_q <= {sync_q[1:0], tx_clock_input};
         idle_q <= idle_d;
         loss_q <= loss_d;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   chk_tclk_loss_set: assert property (
      !toggle && idle_q == LIMIT[7:0] |=> loss_q)
      else $error("clock loss not flagged after idle limit");
   chk_tclk_loss_clear: assert property (
      toggle |=> !loss_q)
      else $error("clock loss still flagged after a toggle");

endmodule

/* core/lsib_top.sv */
// Per-channel line status, latched event and error counter registers.
// Assumes detectors on clk drive the live inputs and one-cycle event pulses.
// Notes on behaviour
// - Alarm indication live bit 1 follows the received all-ones alarm.
// - Unmasked alarm bit interrupts on rise, or any change when edge-select is one.
// - Loss-of-signal live bit 0 follows line pair signal loss; resets to zero.
// - Unmasked loss bit interrupts on rise, or either change with edge-select one.
// - Second live register bit 5 shows far-end loopback closed; other bits zero.
// - Reading the first event latch register clears it to zero.
// - First latch: loop-up code events bit 6, loop-down code events bit 5.
// - First latch: pattern sync events bit 4, transmit clock loss events bit 3.
// - First latch: driver fault bit 2, alarm bit 1, signal loss bit 0; bit 7 zero.
// - Reading the second latch register clears it and withdraws its interrupt.
// - Second latch: pulse amplitude overflow 7, jitter over 6, jitter under 5.
// - Second latch: pattern bit errors bit 4, excess zeros bit 3.
// - Second latch: code violation 2, one-second tick 1, counter wrap 0.
// - Counter low byte register shows error counter bits 7 to 0; resets zero.
// - Transmit clock loss set after more than 70 master cycles without toggling.
// - Counter high byte register shows error counter bits 15 to 8.
module lsib_top #(
   parameter int NCH = lsib_pkg::NCH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   output logic irq_q,
   input wire logic [NCH-1:0] signal_loss_live,
   input wire logic [NCH-1:0] alarm_ind_live,
   input wire logic [NCH-1:0] driver_fault_live,
   input wire logic [NCH-1:0] pattern_sync_live,
   input wire logic [NCH-1:0] loop_down_live,
   input wire logic [NCH-1:0] loop_up_live,
   input wire logic [NCH-1:0] far_loop_live,
   input wire logic [NCH-1:0] tx_clock_input,
   input wire logic [8*NCH-1:0] event_b_in,
   input wire logic [NCH-1:0] error_count_inc
);

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] edge_events(input logic [7:0] cur,
                                              input logic [7:0] prev,
                                              input logic [7:0] sel);
      edge_events = (cur & ~prev) | (sel & ~cur & prev);
   endfunction

   function automatic logic hit(input logic [7:0] addr,
                                input int ch,
                                input logic [5:0] off);
      hit = addr[7:lsib_pkg::CH_LSB] == ch[1:0] && addr[5:0] == off;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [NCH-1:0] tclk_loss;
   logic [7:0] live_a [NCH];
   logic [7:0] ev_a [NCH];
   logic [7:0] ev_b [NCH];
   logic [7:0] prev_q [NCH];
   logic [7:0] latch_a_q [NCH];
   logic [7:0] latch_a_d [NCH];
   logic [7:0] latch_b_q [NCH];
   logic [7:0] latch_b_d [NCH];
   logic [7:0] mask_a_q [NCH];
   logic [7:0] mask_a_d [NCH];
   logic [7:0] mask_b_q [NCH];
   logic [7:0] mask_b_d [NCH];
   logic [7:0] edge_q [NCH];
   logic [7:0] edge_d [NCH];
   logic [15:0] cnt_q [NCH];
   logic [15:0] cnt_d [NCH];
   logic [7:0] rdata_d;
   logic irq_d;

   // ------------------------------------------------------------
   // Transmit clock watchdogs
   // ------------------------------------------------------------
   for (genvar g = 0; g < NCH; g++)
   begin : g_watch
      lsib_tclk_watch #(
         .LIMIT(lsib_pkg::TCLK_LOSS_CYC)
      ) u_watch (
         .clk(clk),
         .resetn(resetn),
         .tx_clock_input(tx_clock_input[g]),
         .loss_q(tclk_loss[g])
      );
   end

   // ------------------------------------------------------------
   // Live status and event detection
   // ------------------------------------------------------------
   always_comb
   begin
      for (int c = 0; c < NCH; c++)
      begin
         live_a[c] = 8'h00;
         live_a[c][lsib_pkg::BIT_LOS] = signal_loss_live[c];
         live_a[c][lsib_pkg::BIT_AIS] = alarm_ind_live[c];
         live_a[c][lsib_pkg::BIT_DF] = driver_fault_live[c];
         live_a[c][lsib_pkg::BIT_TCLK] = tclk_loss[c];
         live_a[c][lsib_pkg::BIT_SYNC] = pattern_sync_live[c];
         live_a[c][lsib_pkg::BIT_LDN] = loop_down_live[c];
         live_a[c][lsib_pkg::BIT_LUP] = loop_up_live[c];
         // Bit 7 has no source and stays zero
         ev_a[c] = edge_events(live_a[c], prev_q[c], edge_q[c])
                   & lsib_pkg::LATCH_A_USED;
      end
   end

   // ------------------------------------------------------------
   // Latches, masks, edge selects and counters
   // ------------------------------------------------------------
   always_comb
   begin
      logic [16:0] sum;
      logic [7:0] clr_a;
      logic [7:0] clr_b;
      sum = 17'h00000;
      clr_a = 8'h00;
      clr_b = 8'h00;
      irq_d = 1'b0;
      for (int c = 0; c < NCH; c++)
      begin
         sum = {1'b0, cnt_q[c]} + {16'h0000, error_count_inc[c]};
         cnt_d[c] = sum[15:0];
         ev_b[c] = event_b_in[8*c +: 8];
         ev_b[c][lsib_pkg::BIT_WRAP] = ev_b[c][lsib_pkg::BIT_WRAP] | sum[16];
         clr_a = 8'h00;
         clr_b = 8'h00;
         if (reg_rd && hit(reg_addr, c, lsib_pkg::OFF_LATCH_A))
         begin
            clr_a = 8'hFF;
         end
         if (reg_rd && hit(reg_addr, c, lsib_pkg::OFF_LATCH_B))
         begin
            clr_b = 8'hFF;
         end
         if (reg_wr && hit(reg_addr, c, lsib_pkg::OFF_LATCH_A))
         begin
            clr_a = reg_wdata;
         end
         if (reg_wr && hit(reg_addr, c, lsib_pkg::OFF_LATCH_B))
         begin
            clr_b = reg_wdata;
         end
         // A new event in the clearing cycle survives
         latch_a_d[c] = (latch_a_q[c] & ~clr_a) | ev_a[c];
         latch_b_d[c] = (latch_b_q[c] & ~clr_b) | ev_b[c];
         mask_a_d[c] = mask_a_q[c];
         mask_b_d[c] = mask_b_q[c];
         edge_d[c] = edge_q[c];
         if (reg_wr && hit(reg_addr, c, lsib_pkg::OFF_MASK_A))
         begin
            mask_a_d[c] = reg_wdata;
         end
         if (reg_wr && hit(reg_addr, c, lsib_pkg::OFF_MASK_B))
         begin
            mask_b_d[c] = reg_wdata;
         end
         if (reg_wr && hit(reg_addr, c, lsib_pkg::OFF_EDGE_A))
         begin
            edge_d[c] = reg_wdata;
         end
         irq_d = irq_d | (|(latch_a_d[c] & ~mask_a_d[c]))
                       | (|(latch_b_d[c] & ~mask_b_d[c]));
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_comb
   begin
      logic [1:0] ch;
      ch = reg_addr[7:lsib_pkg::CH_LSB];
      rdata_d = 8'h00;
      if (reg_rd)
      begin
         case (reg_addr[5:0])
            lsib_pkg::OFF_LIVE_A: rdata_d = live_a[ch];
            lsib_pkg::OFF_LIVE_B:
            begin
               rdata_d[lsib_pkg::BIT_FAR_LOOP] = far_loop_live[ch];
            end
            lsib_pkg::OFF_LATCH_A: rdata_d = latch_a_q[ch];
            lsib_pkg::OFF_LATCH_B: rdata_d = latch_b_q[ch];
            lsib_pkg::OFF_CNT_LO: rdata_d = cnt_q[ch][7:0];
            lsib_pkg::OFF_CNT_HI: rdata_d = cnt_q[ch][15:8];
            lsib_pkg::OFF_MASK_A: rdata_d = mask_a_q[ch];
            lsib_pkg::OFF_MASK_B: rdata_d = mask_b_q[ch];
            lsib_pkg::OFF_EDGE_A: rdata_d = edge_q[ch];
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int c = 0; c < NCH; c++)
         begin
            prev_q[c] <= 8'h00;
            latch_a_q[c] <= lsib_pkg::LATCH_RST;
            latch_b_q[c] <= lsib_pkg::LATCH_RST;
            mask_a_q[c] <= lsib_pkg::MASK_RST;
            mask_b_q[c] <= lsib_pkg::MASK_RST;
            edge_q[c] <= lsib_pkg::EDGE_RST;
            cnt_q[c] <= lsib_pkg::CNT_RST;
         end
         reg_rdata_q <= 8'h00;
         irq_q <= 1'b0;
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            prev_q[c] <= live_a[c];
            latch_a_q[c] <= latch_a_d[c];
            latch_b_q[c] <= latch_b_d[c];
            mask_a_q[c] <= mask_a_d[c];
            mask_b_q[c] <= mask_b_d[c];
            edge_q[c] <= edge_d[c];
            cnt_q[c] <= cnt_d[c];
         end
         reg_rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   // ------------------------------------------------------------
   // Checks on channel 0 and the interrupt output
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   chk_live_alarm_read: assert property (
      reg_rd && reg_addr == {2'b00, lsib_pkg::OFF_LIVE_A}
      |=> reg_rdata_q[lsib_pkg::BIT_AIS] == $past(alarm_ind_live[0])
          && reg_rdata_q[lsib_pkg::BIT_LOS] == $past(signal_loss_live[0]))
      else $error("live status read mismatch");

   chk_alarm_rise_latch: assert property (
      $rose(alarm_ind_live[0]) && !reg_wr
      |=> latch_a_q[0][lsib_pkg::BIT_AIS])
      else $error("alarm rise not latched");

   chk_los_fall_latch: assert property (
      $fell(signal_loss_live[0]) && edge_q[0][lsib_pkg::BIT_LOS] && !reg_wr
      |=> latch_a_q[0][lsib_pkg::BIT_LOS])
      else $error("loss fall not latched with any-change select");

   chk_los_fall_ignored: assert property (
      $fell(signal_loss_live[0]) && !edge_q[0][lsib_pkg::BIT_LOS]
      && !latch_a_q[0][lsib_pkg::BIT_LOS]
      |=> !latch_a_q[0][lsib_pkg::BIT_LOS])
      else $error("loss fall latched with rise-only select");

   chk_latch_a_clear: assert property (
      reg_rd && reg_addr == {2'b00, lsib_pkg::OFF_LATCH_A} && ev_a[0] == 8'h00
      |=> latch_a_q[0] == 8'h00 && reg_rdata_q == $past(latch_a_q[0]))
      else $error("first latch not cleared by read");

   chk_latch_b_clear: assert property (
      reg_rd && reg_addr == {2'b00, lsib_pkg::OFF_LATCH_B} && ev_b[0] == 8'h00
      |=> latch_b_q[0] == 8'h00)
      else $error("second latch not cleared by read");

   chk_bit7_zero: assert property (
      latch_a_q[0][7] == 1'b0)
      else $error("reserved latch bit set");

   chk_latch_sticky: assert property (
      latch_b_q[0][lsib_pkg::BIT_WRAP] && !reg_rd && !reg_wr
      |=> latch_b_q[0][lsib_pkg::BIT_WRAP])
      else $error("latched bit lost without a read");

   chk_count_high_read: assert property (
      reg_rd && reg_addr == {2'b00, lsib_pkg::OFF_CNT_HI}
      |=> reg_rdata_q == $past(cnt_q[0][15:8]))
      else $error("counter high byte read mismatch");

   chk_count_wrap: assert property (
      cnt_q[0] == 16'hFFFF && error_count_inc[0]
      |=> cnt_q[0] == 16'h0000 && latch_b_q[0][lsib_pkg::BIT_WRAP])
      else $error("counter wrap not latched");

   chk_alarm_fall_latch: assert property (
      $fell(alarm_ind_live[0]) && edge_q[0][lsib_pkg::BIT_AIS] && !reg_wr
      |=> latch_a_q[0][lsib_pkg::BIT_AIS])
      else $error("alarm fall not latched with any-change select");

   chk_far_loop_read: assert property (
      reg_rd && reg_addr == {2'b00, lsib_pkg::OFF_LIVE_B}
      |=> reg_rdata_q == {2'b00, $past(far_loop_live[0]), 5'b00000})
      else $error("second live register read mismatch");

   chk_read_event_wins: assert property (
      reg_rd && reg_addr == {2'b00, lsib_pkg::OFF_LATCH_B} && ev_b[0] != 8'h00
      |=> (latch_b_q[0] & $past(ev_b[0])) == $past(ev_b[0]))
      else $error("event lost in the read clearing cycle");

   chk_pulse_event_latch: assert property (
      event_b_in[7:0] != 8'h00
      |=> (latch_b_q[0] & $past(event_b_in[7:0])) == $past(event_b_in[7:0]))
      else $error("second latch missed an event pulse");

   chk_count_low_read: assert property (
      reg_rd && reg_addr == {2'b00, lsib_pkg::OFF_CNT_LO}
      |=> reg_rdata_q == $past(cnt_q[0][7:0]))
      else $error("counter low byte read mismatch");

   chk_count_step: assert property (
      error_count_inc[0] && cnt_q[0] != 16'hFFFF
      |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
      else $error("error counter did not step");

   chk_count_hold: assert property (
      !error_count_inc[0]
      |=> cnt_q[0] == $past(cnt_q[0]))
      else $error("error counter moved without an increment");

   chk_irq_level: assert property (
      ##1 irq_q == ((|(latch_a_q[0] & ~mask_a_q[0])) || (|(latch_b_q[0] & ~mask_b_q[0]))
                    || (|(latch_a_q[1] & ~mask_a_q[1])) || (|(latch_b_q[1] & ~mask_b_q[1]))
                    || (|(latch_a_q[2] & ~mask_a_q[2])) || (|(latch_b_q[2] & ~mask_b_q[2]))
                    || (|(latch_a_q[3] & ~mask_a_q[3])) || (|(latch_b_q[3] & ~mask_b_q[3]))))
      else $error("interrupt output disagrees with pending bits");

endmodule

/* pkg/lsib_pkg.sv */
// Shared constants of the line status interrupt bank.
// Assumes an 8-bit register address: channel in bits 7:6, offset below.
package lsib_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NCH = 4;
   localparam int ADDR_W = 8;
   localparam int CH_LSB = 6;

   // ------------------------------------------------------------
   // Register offsets within one channel
   // ------------------------------------------------------------
   localparam logic [5:0] OFF_LIVE_A = 6'h14;
   localparam logic [5:0] OFF_LIVE_B = 6'h15;
   localparam logic [5:0] OFF_LATCH_A = 6'h16;
   localparam logic [5:0] OFF_LATCH_B = 6'h17;
   localparam logic [5:0] OFF_CNT_LO = 6'h18;
   localparam logic [5:0] OFF_CNT_HI = 6'h19;
   localparam logic [5:0] OFF_MASK_A = 6'h20;
   localparam logic [5:0] OFF_MASK_B = 6'h21;
   localparam logic [5:0] OFF_EDGE_A = 6'h22;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_LOS = 0;
   localparam int BIT_AIS = 1;
   localparam int BIT_DF = 2;
   localparam int BIT_TCLK = 3;
   localparam int BIT_SYNC = 4;
   localparam int BIT_LDN = 5;
   localparam int BIT_LUP = 6;
   localparam int BIT_FAR_LOOP = 5;
   localparam int BIT_WRAP = 0;
   localparam logic [7:0] LATCH_A_USED = 8'h7F;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'hFF;
   localparam logic [7:0] EDGE_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;

   // ------------------------------------------------------------
   // Timing: idle master clock cycles before transmit clock loss
   // ------------------------------------------------------------
   localparam int TCLK_LOSS_CYC = 70;

endpackage

/* tb/lsib_line_model.sv */
// Line-side model: one transmit clock per channel, each can be stopped.
// Assumes the bench owns clk; these clocks are unrelated to it in phase.
module lsib_line_model #(
   parameter int NCH = 4
) (
   input wire logic [NCH-1:0] run,
   output logic [NCH-1:0] tx_clock
);
   timeunit 1ns;
   timeprecision 1ps;

   logic osc = 1'b0;

   // ----------------------------------------
   // Free oscillator, 14 ns period
   // ----------------------------------------
   always #7 osc = ~osc;

   // Stopped channel stands still at 0
   assign tx_clock = run & {NCH{osc}};
endmodule

/* tb/lsib_top_test.sv */
// Self-checking bench for the line status interrupt bank.
// Assumes a 125 MHz clock and the register map of lsib_pkg.
module lsib_top_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata_q;
   logic irq_q;
   logic [3:0] los = 4'h0, ais = 4'h0, df = 4'h0, syn = 4'h0;
   logic [3:0] ldn = 4'h0, lup = 4'h0, far = 4'h0, inc = 4'h0;
   logic [3:0] run = 4'hF;
   logic [3:0] txc;
   logic [31:0] evb = 32'h0;
   int errors = 0;
   int num_checks = 0;

   always #4 clk = ~clk;

   lsib_line_model #(.NCH(4)) line (.run(run), .tx_clock(txc));

   lsib_top #(.NCH(4)) dut (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q),
      .signal_loss_live(los), .alarm_ind_live(ais), .driver_fault_live(df),
      .pattern_sync_live(syn), .loop_down_live(ldn), .loop_up_live(lup),
      .far_loop_live(far), .tx_clock_input(txc), .event_b_in(evb),
      .error_count_inc(inc)
   );

   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   function automatic logic [7:0] adr(input int ch, input logic [5:0] off);
      return {ch[1:0], off};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   initial
   begin
      #(20000 * 8);
      errors++;
      final_report;
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      // Reset values, unmapped and read-only places
      for (int i = 0; i < 6; i++)
      begin
         rdc(adr(0, lsib_pkg::OFF_LIVE_A + 6'(i)), 8'h00);
      end
      rdc(adr(0, lsib_pkg::OFF_MASK_A), 8'hFF);
      rdc(adr(0, lsib_pkg::OFF_EDGE_A), 8'h00);
      rdc(adr(0, 6'h3F), 8'h00);
      wr(adr(0, lsib_pkg::OFF_LIVE_A), 8'hFF);
      rdc(adr(0, lsib_pkg::OFF_LIVE_A), 8'h00);
      chk({7'h0, irq_q}, 8'h00);
      $display("test reset done");

      // Live bits and first latch layout, channel 0
      @(posedge clk);
      {los[0], ais[0], df[0], syn[0], ldn[0], lup[0], far[0]} <= 7'h7F;
      tick(2);
      rdc(adr(0, lsib_pkg::OFF_LIVE_A), 8'h77);
      rdc(adr(0, lsib_pkg::OFF_LIVE_B), 8'h20);
      rdc(adr(0, lsib_pkg::OFF_LATCH_A), 8'h77);
      rdc(adr(0, lsib_pkg::OFF_LATCH_A), 8'h00);
      @(posedge clk);
      {los[0], ais[0], df[0], syn[0], ldn[0], lup[0], far[0]} <= 7'h00;
      tick(2);
      rdc(adr(0, lsib_pkg::OFF_LATCH_A), 8'h00);
      rdc(adr(0, lsib_pkg::OFF_LIVE_B), 8'h00);
      wr(adr(0, lsib_pkg::OFF_EDGE_A), 8'h7F);
      {los[0], ais[0], df[0], syn[0], ldn[0], lup[0]} <= 6'h3F;
      tick(2);
      rdc(adr(0, lsib_pkg::OFF_LATCH_A), 8'h77);
      @(posedge clk);
      {los[0], ais[0], df[0], syn[0], ldn[0], lup[0]} <= 6'h00;
      tick(3);
      rdc(adr(0, lsib_pkg::OFF_LATCH_A), 8'h77);
      rdc(adr(0, lsib_pkg::OFF_LIVE_A), 8'h00);
      rdc(adr(0, lsib_pkg::OFF_EDGE_A), 8'h7F);
      $display("test first latch done");

      // Interrupt and mask, channel 0 alarm
      wr(adr(0, lsib_pkg::OFF_MASK_A), 8'h00);
      ais[0] <= 1'b1;
      tick(2);
      chk({7'h0, irq_q}, 8'h01);
      tick(5);
      chk({7'h0, irq_q}, 8'h01);
      rdc(adr(0, lsib_pkg::OFF_LATCH_A), 8'h02);
      tick(1);
      chk({7'h0, irq_q}, 8'h00);
      wr(adr(0, lsib_pkg::OFF_MASK_A), 8'h02);
      ais[0] <= 1'b0;
      @(posedge clk);
      ais[0] <= 1'b1;
      tick(2);
      chk({7'h0, irq_q}, 8'h00);
      wr(adr(0, lsib_pkg::OFF_MASK_A), 8'h00);
      tick(2);
      chk({7'h0, irq_q}, 8'h01);
      rdc(adr(0, lsib_pkg::OFF_LATCH_A), 8'h02);
      $display("test interrupt done");

      // Second latch, each source of channel 0
      wr(adr(0, lsib_pkg::OFF_MASK_B), 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk);
         evb <= 32'h1 << i;
         @(posedge clk);
         evb <= 32'h0;
         tick(2);
         chk({7'h0, irq_q}, 8'h01);
         rdc(adr(0, lsib_pkg::OFF_LATCH_B), 8'h01 << i);
         tick(1);
         chk({7'h0, irq_q}, 8'h00);
         rdc(adr(0, lsib_pkg::OFF_LATCH_B), 8'h00);
      end
      // Event in the read clearing cycle survives
      fork
         rdc(adr(0, lsib_pkg::OFF_LATCH_B), 8'h00);
         begin
            @(posedge clk);
            evb <= 32'h00000008;
            @(posedge clk);
            evb <= 32'h00000000;
         end
      join
      rdc(adr(0, lsib_pkg::OFF_LATCH_B), 8'h08);
      // Writing ones clears only those bits
      @(posedge clk);
      evb <= 32'h0000000C;
      @(posedge clk);
      evb <= 32'h00000000;
      wr(adr(0, lsib_pkg::OFF_LATCH_B), 8'h08);
      rdc(adr(0, lsib_pkg::OFF_LATCH_B), 8'h04);
      rdc(adr(0, lsib_pkg::OFF_MASK_B), 8'h00);
      rdc(adr(1, lsib_pkg::OFF_MASK_A), 8'hFF);
      rdc(adr(1, lsib_pkg::OFF_EDGE_A), 8'h00);
      $display("test second latch done");

      // Error counter, channel 0: 300 increments
      for (int i = 0; i < 300; i++)
      begin
         @(posedge clk);
         inc[0] <= 1'b1;
         @(posedge clk);
         inc[0] <= 1'b0;
      end
      tick(2);
      rdc(adr(0, lsib_pkg::OFF_CNT_LO), 8'h2C);
      rdc(adr(0, lsib_pkg::OFF_CNT_HI), 8'h01);
      $display("test counter done");

      // Transmit clock loss and recovery, channel 3
      @(posedge clk);
      run[3] <= 1'b0;
      tick(60);
      rdc(adr(3, lsib_pkg::OFF_LIVE_A), 8'h00);
      tick(30);
      rdc(adr(3, lsib_pkg::OFF_LIVE_A), 8'h08);
      rdc(adr(3, lsib_pkg::OFF_LATCH_A), 8'h08);
      @(posedge clk);
      run[3] <= 1'b1;
      tick(10);
      rdc(adr(3, lsib_pkg::OFF_LIVE_A), 8'h00);
      rdc(adr(3, lsib_pkg::OFF_LATCH_A), 8'h00);
      $display("test clock loss done");
      final_report;
   end
endmodule
